//--- wdg_watchdog.sv
// Purpose: watchdog timeout selection, reset enable and apb register file
// Assumes: arst_n_i is the power-on reset; clock_i runs at 125 MHz
// Notes:   the oscillator is modelled as a divided tick of clock_i
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module wdg_watchdog #(
  parameter int unsigned BASE_CYC = wdg_pkg::BASE_CYCLES,
  parameter int unsigned OSC_DIV  = wdg_pkg::OSC_DIV
) (
  input  wire logic                        clock_i,          // 125 MHz clock
  input  wire logic                        arst_n_i,         // power-on reset, low
  input  wire logic                        psel,             // apb select
  input  wire logic                        penable,          // apb enable
  input  wire logic                        pwrite,           // apb direction
  input  wire logic [wdg_pkg::ADDR_W-1:0]  paddr,            // apb address
  input  wire logic [wdg_pkg::DATA_W-1:0]  pwdata,           // apb write data
  output logic      [wdg_pkg::DATA_W-1:0]  prdata,           // apb read data
  output logic                             pready,           // apb ready
  output logic                             pslverr,          // apb error
  input  wire logic                        always_on_fuse_i, // fuse forces reset mode
  input  wire logic                        irq_serviced_i,   // timeout vector taken
  output logic                             timeout_irq_o,    // timeout interrupt request
  output logic                             sys_reset_o,      // watchdog reset pulse
  output logic      [15:0]                 restart_vector_o, // restart address
  output logic                             irq_o             // masked event interrupt
);
  import wdg_pkg::*;

  logic [SEL_W-1:0] timeout_select;
  logic             reset_enable_bit;
  logic             timeout_irq_enable;
  logic             timeout_irq_flag;
  logic [2:0]       unlock_cnt;
  logic             change_unlock_bit;
  logic             dog_reset_flag;
  logic [EV_W-1:0]  ev_status;
  logic [EV_W-1:0]  ev_mask;
  logic [9:0]       div_cnt;
  logic             osc_tick;
  logic             expire;
  logic             running;
  logic             rst_mode;
  logic             do_reset;
  logic             do_irq;
  logic             setup;
  logic             access_wr;
  logic             mapped;
  logic [7:0]       ctrl_rd;
  logic [7:0]       wb;

  // apb decode: read data is latched in setup, so every access ends in one access cycle
  assign setup     = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign wb        = pwdata[7:0];
  always_comb
  begin
    if (paddr == OFF_CTRL || paddr == OFF_CAUSE || paddr == OFF_STAT)
      mapped = 1'b1;
    else if (paddr == OFF_MASK || paddr == OFF_KICK || paddr == OFF_VECTOR)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  assign change_unlock_bit = (unlock_cnt != 3'h0);
  assign ctrl_rd = {timeout_irq_flag, timeout_irq_enable, timeout_select[SEL_W-1], change_unlock_bit,
                    reset_enable_bit, timeout_select[SEL_LO_W-1:0]};

  // oscillator tick; OSC_DIV is rounded down so periods run marginally short
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      div_cnt <= '0;
    else if (div_cnt == 10'(OSC_DIV - 1))
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 10'h001;
  end
  assign osc_tick = (div_cnt == 10'(OSC_DIV - 1));

  // mode decode
  assign rst_mode = reset_enable_bit || always_on_fuse_i;
  assign running  = rst_mode || timeout_irq_enable;
  // reset when interrupt is off, fused, or the first timeout went unserviced
  assign do_reset = expire && (always_on_fuse_i ||
                    (reset_enable_bit && (!timeout_irq_enable || timeout_irq_flag)));
  assign do_irq   = expire && !do_reset && timeout_irq_enable;

  wdg_timeout_counter #(
    .BASE  (BASE_CYC),
    .WIDTH (CNT_W)
  ) u_counter (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .run_i    (running),
    .kick_i   ((access_wr && paddr == OFF_KICK) || sys_reset_o),
    .tick_i   (osc_tick),
    .select_i (timeout_select),
    .expire_o (expire)
  );

  // timeout select: changes only inside the unlock window or on a watchdog reset
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      timeout_select <= CTRL_RESET[SEL_W-1:0];
    else if (do_reset)
      timeout_select <= CTRL_RESET[SEL_W-1:0];
    else if (access_wr && paddr == OFF_CTRL && change_unlock_bit)
      timeout_select <= {wb[POS_SEL_HI], wb[POS_SEL_LO +: SEL_LO_W]};
  end

  // reset enable: set freely, cleared only when unlocked and flag clear
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reset_enable_bit <= CTRL_RESET[POS_RST_EN];
    else if (dog_reset_flag || do_reset)
      reset_enable_bit <= 1'b1;
    else if (access_wr && paddr == OFF_CTRL)
    begin
      if (wb[POS_RST_EN])
        reset_enable_bit <= 1'b1;
      else if (change_unlock_bit)
        reset_enable_bit <= 1'b0;
    end
  end

  // unlock window counter
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      unlock_cnt <= 3'h0;
    else if (do_reset)
      unlock_cnt <= 3'h0;
    else if (access_wr && paddr == OFF_CTRL && wb[POS_UNLOCK])
      unlock_cnt <= UNLOCK_LOAD;
    else if (unlock_cnt != 3'h0)
      unlock_cnt <= unlock_cnt - 3'h1;
  end

  // interrupt enable: servicing in combined mode falls back to reset mode
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      timeout_irq_enable <= CTRL_RESET[POS_IRQ_EN];
    else if (do_reset)
      timeout_irq_enable <= 1'b0;
    else if (access_wr && paddr == OFF_CTRL)
      timeout_irq_enable <= wb[POS_IRQ_EN];
    else if (irq_serviced_i && reset_enable_bit)
      timeout_irq_enable <= 1'b0;
  end

  // interrupt flag: a timeout in the clearing cycle wins
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      timeout_irq_flag <= CTRL_RESET[POS_IRQ_FLAG];
    else if (do_reset)
      timeout_irq_flag <= 1'b0;
    else if (do_irq)
      timeout_irq_flag <= 1'b1;
    else if (irq_serviced_i || (access_wr && paddr == OFF_CTRL && wb[POS_IRQ_FLAG]))
      timeout_irq_flag <= 1'b0;
  end
  assign timeout_irq_o = timeout_irq_flag && timeout_irq_enable;

  // watchdog reset flag, cleared by writing zero; only power-on reset clears it otherwise
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      dog_reset_flag <= 1'b0;
    else if (do_reset)
      dog_reset_flag <= 1'b1;
    else if (access_wr && paddr == OFF_CAUSE && !wb[POS_DOG_FLAG])
      dog_reset_flag <= 1'b0;
  end

  // reset pulse and restart vector
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sys_reset_o <= 1'b0;
    else
      sys_reset_o <= do_reset;
  end
  assign restart_vector_o = RESET_VECTOR;

  // sticky events, write one to clear, set wins
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ev_status <= '0;
    else
      ev_status <= (ev_status & ~((access_wr && paddr == OFF_STAT) ? wb[EV_W-1:0] : 2'h0))
                   | {do_reset, do_irq};
  end

  // event mask
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ev_mask <= MASK_RESET;
    else if (access_wr && paddr == OFF_MASK)
      ev_mask <= wb[EV_W-1:0];
  end
  assign irq_o = |(ev_status & ev_mask);

  // read data and error, captured in the setup cycle
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= !mapped;
      if (pwrite)
        prdata <= '0;
      else if (paddr == OFF_CTRL)
        prdata <= {24'h000000, ctrl_rd};
      else if (paddr == OFF_CAUSE)
        prdata <= {28'h0000000, dog_reset_flag, 3'h0};
      else if (paddr == OFF_STAT)
        prdata <= {30'h0, ev_status};
      else if (paddr == OFF_MASK)
        prdata <= {30'h0, ev_mask};
      else if (paddr == OFF_VECTOR)
        prdata <= {16'h0000, RESET_VECTOR};
      else
        prdata <= '0;
    end
  end

  // checks
  chk_flag_forces_en: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    dog_reset_flag |=> reset_enable_bit)
    else $error("reset enable low while reset flag set");
  chk_locked_no_clear: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (reset_enable_bit && !change_unlock_bit && !do_reset) |=> reset_enable_bit)
    else $error("reset enable cleared without unlock");
  chk_unlock_window: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (access_wr && paddr == OFF_CTRL && wb[POS_UNLOCK] && !do_reset) |=> change_unlock_bit [*4] ##1 !change_unlock_bit)
    else $error("unlock window not four cycles");
  chk_select_locked: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (!change_unlock_bit && !do_reset) |=> $stable(timeout_select))
    else $error("select changed while locked");
  chk_min_period: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (osc_tick && running && timeout_select == 4'h0 && u_counter.count == CNT_W'(BASE_CYC - 1)
     && !(access_wr && paddr == OFF_KICK) && !sys_reset_o) |=> expire)
    else $error("code zero did not expire after base count");
  chk_clamp_reserved: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (timeout_select > SEL_MAX) |-> (u_counter.limit == (CNT_W'(BASE_CYC) << 9)))
    else $error("reserved code not clamped");
  chk_reset_flag_set: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    do_reset |=> (dog_reset_flag && sys_reset_o))
    else $error("watchdog reset did not set flag");
  chk_irq_first: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (expire && reset_enable_bit && timeout_irq_enable && !timeout_irq_flag && !always_on_fuse_i)
      |=> (timeout_irq_flag && !sys_reset_o))
    else $error("combined mode did not interrupt first");
  chk_service_fallback: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (irq_serviced_i && reset_enable_bit && !(access_wr && paddr == OFF_CTRL)) |=> !timeout_irq_enable)
    else $error("service did not fall back to reset mode");
  chk_vector_zero: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    sys_reset_o |-> restart_vector_o == 16'h0000)
    else $error("restart vector not zero");

  cov_irq_then_reset: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    do_irq ##[1:1000] do_reset);
  cov_unlock_clear: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    change_unlock_bit ##1 $fell(reset_enable_bit));
  cov_service: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    timeout_irq_flag && irq_serviced_i);
endmodule : wdg_watchdog

//--- wdg_pkg.sv
// Purpose: shared constants for the watchdog timeout and reset-enable block
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes:   control word layout follows the 8-bit watchdog control/status byte
package wdg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;  // watchdog_control_status
  localparam logic [ADDR_W-1:0] OFF_CAUSE  = 8'h04;  // reset_cause_register
  localparam logic [ADDR_W-1:0] OFF_STAT   = 8'h08;  // sticky event status
  localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h0c;  // event mask
  localparam logic [ADDR_W-1:0] OFF_KICK   = 8'h10;  // any write restarts the count
  localparam logic [ADDR_W-1:0] OFF_VECTOR = 8'h14;  // restart vector, read only

  // control field positions
  localparam int unsigned POS_IRQ_FLAG = 7;
  localparam int unsigned POS_IRQ_EN   = 6;
  localparam int unsigned POS_SEL_HI   = 5;
  localparam int unsigned POS_UNLOCK   = 4;
  localparam int unsigned POS_RST_EN   = 3;
  localparam int unsigned POS_SEL_LO   = 0;
  localparam int unsigned SEL_LO_W     = 3;
  localparam int unsigned SEL_W        = 4;

  // reset cause field and event status bits
  localparam int unsigned POS_DOG_FLAG = 3;
  localparam int unsigned EV_TIMEOUT   = 0;
  localparam int unsigned EV_DOG_RST   = 1;
  localparam int unsigned EV_W         = 2;

  // reset values
  localparam logic [7:0]      CTRL_RESET = 8'h00;
  localparam logic [EV_W-1:0] MASK_RESET = 2'h0;

  // timeout selection
  localparam int unsigned      BASE_CYCLES = 2048;     // smallest timeout in oscillator cycles
  localparam logic [SEL_W-1:0] SEL_MAX     = 4'h9;     // largest defined code
  localparam int unsigned      CNT_W       = 21;       // holds 2048 << 9

  // nominal oscillator derived from the smallest timeout figure
  localparam int unsigned MIN_TIMEOUT_MS = 16;
  localparam int unsigned MAX_TIMEOUT_MS = 8000;
  localparam int unsigned CLK_HZ         = 125000000;
  localparam int unsigned OSC_HZ         = BASE_CYCLES * 1000 / MIN_TIMEOUT_MS;
  localparam int unsigned OSC_DIV        = CLK_HZ / OSC_HZ;   // rounded down

  // change-unlock window
  localparam int unsigned     UNLOCK_CYCLES = 4;
  localparam logic [2:0]      UNLOCK_LOAD   = 3'h4;

  // shared restart vector
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
endpackage : wdg_pkg

//--- wdg_timeout_counter.sv
// Purpose: timeout counter with select-driven limit
// Assumes: tick_i is one oscillator tick, one clock wide
// Notes:   reserved codes clamp to the longest defined timeout
`timescale 1ns/1ps
module wdg_timeout_counter #(
  parameter int unsigned BASE  = 2048,
  parameter int unsigned WIDTH = 21
) (
  input  wire logic                    clock_i,   // system clock
  input  wire logic                    arst_n_i,  // async reset, low
  input  wire logic                    run_i,     // watchdog running
  input  wire logic                    kick_i,    // restart count
  input  wire logic                    tick_i,    // oscillator tick
  input  wire logic [wdg_pkg::SEL_W-1:0] select_i, // timeout code
  output logic                         expire_o   // one-cycle timeout pulse
);
  import wdg_pkg::*;

  logic [SEL_W-1:0] code_eff;
  logic [WIDTH-1:0] limit;
  logic [WIDTH-1:0] count;
  logic             hit;

  // clamp reserved codes so a stray write cannot disable the timeout
  assign code_eff = (select_i > SEL_MAX) ? SEL_MAX : select_i;
  assign limit    = WIDTH'(BASE) << code_eff;
  // >= so that switching to a shorter period still expires promptly
  assign hit      = tick_i && (count >= limit - WIDTH'(1));

  // count oscillator ticks while running
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      count <= '0;
    else if (kick_i || !run_i || hit)
      count <= '0;
    else if (tick_i)
      count <= count + WIDTH'(1);
  end

  // registered expiry pulse
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      expire_o <= 1'b0;
    else
      expire_o <= hit && run_i && !kick_i;
  end
endmodule : wdg_timeout_counter

//--- wdg_core_model.sv
// Purpose: processor-side model that takes the watchdog timeout vector
// Assumes: one clock; the vector fetch is modelled as a fixed delay
// Notes:   en_i low stalls servicing, so a later timeout can overtake it
`timescale 1ns/1ps
module wdg_core_model #(
  parameter int unsigned LAT = 3
) (
  input  wire logic clock_i,  // system clock
  input  wire logic arst_n_i, // async reset, low
  input  wire logic en_i,     // servicing allowed
  input  wire logic irq_i,    // timeout request level
  output logic      ack_o     // vector taken, one cycle
);
  int unsigned wait_q;
  // wait LAT cycles of request, then take the vector once
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wait_q <= 0;
      ack_o  <= 1'b0;
    end
    else
    begin
      ack_o  <= en_i && irq_i && wait_q == LAT && !ack_o;
      wait_q <= !irq_i ? 0 : ((en_i && wait_q < LAT) ? wait_q + 1 : wait_q);
    end
  end
endmodule : wdg_core_model

//--- testbench.sv
// Purpose: self-checking bench for the watchdog timeout and reset-enable block
// Assumes: small BASE_CYC and OSC_DIV keep every timeout short
// Notes:   one idle edge follows each transfer so no strobe is driven twice per step
`timescale 1ns/1ps
module testbench;
  import wdg_pkg::*;
  localparam int unsigned BC = 16; // shortened base count
  localparam int unsigned DV = 2;  // shortened tick divider
  logic              clock_i  = 1'b0;
  logic              arst_n_i = 1'b0;
  logic              psel     = 1'b0;
  logic              penable  = 1'b0;
  logic              pwrite   = 1'b0;
  logic [ADDR_W-1:0] paddr    = '0;
  logic [31:0]       pwdata   = '0;
  logic              fuse     = 1'b0;
  logic              svc_en   = 1'b1;
  logic [31:0]       prdata, r;
  logic [15:0]       vec;
  logic              pready, pslverr, err, ack, tirq, sys_rst, irq;
  int                error_cnt = 0, comparisons = 0, cyc = 0, n, e;

  wdg_watchdog #(.BASE_CYC(BC), .OSC_DIV(DV)) dut_u (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .always_on_fuse_i(fuse), .irq_serviced_i(ack), .timeout_irq_o(tirq),
    .sys_reset_o(sys_rst), .restart_vector_o(vec), .irq_o(irq));

  wdg_core_model core_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .en_i(svc_en), .irq_i(tirq), .ack_o(ack));

  // free-running 125 MHz clock
  initial
  begin
    forever #4 clock_i = ~clock_i;
  end

  // hang guard: well above the longest planned run
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 70000)
    begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // apb cycle: request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    r   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask : xfer

  // bounded wait for the interrupt (which=1) or the reset pulse
  task automatic wait_sig(input bit which, input int lim);
    n = 0;
    while (((which ? tirq : sys_rst) !== 1'b1) && n < lim)
    begin
      @(posedge clock_i);
      n++;
    end
  endtask : wait_sig

  // kick, clear the flag first, then the unlocked write
  task automatic set_mode(input logic [7:0] v);
    xfer(1, OFF_KICK, 0);
    xfer(1, OFF_CAUSE, 0);
    xfer(1, OFF_CTRL, 32'h18);
    xfer(1, OFF_CTRL, {24'h0, v});
  endtask : set_mode

  initial
  begin
    repeat (16) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    xfer(0, OFF_CTRL, 0);
    chk(r, {24'h0, CTRL_RESET});
    xfer(0, OFF_VECTOR, 0);
    chk(r, 32'h0);
    xfer(0, 8'h40, 0);
    chk({31'h0, err}, 32'h1);
    $display("test reset_values done");
    // every defined code plus one reserved code, reset mode
    for (int s = 0; s < 16; s = (s == 9) ? 15 : s + 1)
    begin
      set_mode({2'b00, s[3], 2'b01, s[2:0]});
      xfer(1, OFF_KICK, 0);
      wait_sig(0, 20000);
      e = (BC << (s > 9 ? 9 : s)) * DV;
      chk(32'(n + 6 >= e && n <= e + 6), 32'h1);
      chk({16'h0, vec}, 32'h0);
    end
    $display("test timeout_codes done");
    xfer(0, OFF_CAUSE, 0);
    chk({31'h0, r[3]}, 32'h1);
    xfer(0, OFF_CTRL, 0);
    chk(r, 32'h08);
    xfer(1, OFF_KICK, 0);
    xfer(1, OFF_CTRL, 32'h18);
    xfer(1, OFF_CTRL, 0);
    xfer(0, OFF_CTRL, 0);
    chk({31'h0, r[3]}, 32'h1);
    set_mode(8'h00);
    xfer(0, OFF_CTRL, 0);
    chk(r, 32'h0);
    xfer(0, OFF_CAUSE, 0);
    chk({31'h0, r[3]}, 32'h0);
    wait_sig(0, 200);
    chk(n, 200);
    $display("test flag_override done");
    // unlock window: open, then closed after four cycles
    xfer(1, OFF_CTRL, 32'h10);
    xfer(0, OFF_CTRL, 0);
    chk({31'h0, r[4]}, 32'h1);
    repeat (6) @(posedge clock_i);
    xfer(1, OFF_CTRL, 32'h03);
    xfer(0, OFF_CTRL, 0);
    chk(r, 32'h0);
    xfer(1, OFF_CTRL, 32'h10);
    xfer(1, OFF_CTRL, 32'h21);
    xfer(0, OFF_CTRL, 0);
    chk(r, 32'h21);
    $display("test unlock done");
    // interrupt first, serviced, then the next timeout resets
    xfer(1, OFF_MASK, 32'h1);
    set_mode(8'h48);
    wait_sig(1, 200);
    chk(32'(n < 200 && sys_rst === 1'b0), 32'h1);
    @(posedge clock_i);
    chk({31'h0, irq}, 32'h1);
    repeat (6) @(posedge clock_i);
    xfer(0, OFF_CTRL, 0);
    chk(r, 32'h08);
    wait_sig(0, 100);
    chk(32'(n < 100), 32'h1);
    // interrupt-only mode: service clears the flag but keeps the enable
    set_mode(8'h40);
    wait_sig(1, 200);
    chk(32'(n < 200 && sys_rst === 1'b0), 32'h1);
    repeat (8) @(posedge clock_i);
    xfer(0, OFF_CTRL, 0);
    chk(r, 32'h40);
    // combined mode with servicing stalled: the second timeout resets
    svc_en <= 1'b0;
    set_mode(8'h48);
    wait_sig(1, 200);
    chk(32'(n < 200 && sys_rst === 1'b0), 32'h1);
    repeat (8) @(posedge clock_i);
    chk({31'h0, tirq}, 32'h1);
    wait_sig(0, 100);
    chk(32'(n < 100), 32'h1);
    svc_en <= 1'b1;
    set_mode(8'h00);
    xfer(0, OFF_STAT, 0);
    chk(r, 32'h3);
    xfer(1, OFF_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    xfer(1, OFF_MASK, 32'h2);
    chk({31'h0, irq}, 32'h1);
    xfer(1, OFF_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    $display("test irq_then_reset done");
    // fuse forces reset mode with the control bits cleared
    fuse <= 1'b1;
    xfer(1, OFF_KICK, 0);
    wait_sig(0, 100);
    chk(32'(n < 100), 32'h1);
    fuse <= 1'b0;
    $display("test fuse done");
    close_out();
  end
endmodule : testbench
